// file: hdl/nand_feat_pkg.sv
// package: register map, command codes, timing counts and carriers
package nand_feat_pkg;
  localparam int CLK_MHZ = 125;
  // host-side register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0090;
  localparam logic [31:0] WDATA_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // ctrl and status bits
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_GET_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  // command codes
  localparam logic [7:0] CMD_SET = 8'hef;
  localparam logic [7:0] CMD_GET = 8'hee;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // feature addresses and values
  localparam logic [7:0] FEAT_TIMING = 8'h01;
  localparam logic [7:0] FEAT_DRIVE = 8'h80;
  localparam logic [7:0] FEAT_RB_PULL = 8'h81;
  localparam logic [7:0] FEAT_ARRAY = 8'h90;
  localparam logic [7:0] ARRAY_NORMAL = 8'h00;
  localparam logic [7:0] ARRAY_OTP = 8'h01;
  localparam logic [7:0] ARRAY_OTP_PROT = 8'h03;
  localparam logic [7:0] ARRAY_ECC_ON = 8'h08;
  localparam logic [7:0] TIMING_MODE_MAX = 8'h05;
  localparam int STATUS_RDY_BIT = 6;
  // pin timing in ns, counts derived (least times rounded up)
  localparam int T_WP_NS = 50;
  localparam int T_ADL_NS = 200;
  localparam int T_WB_NS = 200;
  localparam int T_RP_NS = 50;
  localparam int T_REA_NS = 40;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int ADL_CYC = (T_ADL_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int REA_CYC = (T_REA_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // ahb-lite slave side
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_type;

  // nand pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io_out;
    logic io_oe;
  } nand_pins_type;

  // byte-cycle request to the pin sequencer
  typedef enum logic [2:0] {
    CYC_CMD = 3'b000,
    CYC_ADDR = 3'b001,
    CYC_DIN = 3'b010,
    CYC_DOUT = 3'b011,
    CYC_WAIT = 3'b100
  } cyc_kind_type;
endpackage

// file: hdl/rb_sync.sv
// three-stage synchroniser for the ready/busy pin
module rb_sync (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pin and result
  input wire logic pin_in,
  output logic level_out
);
  import nand_feat_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_type;
  sync_state_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // change counts only when stages two and three agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
endmodule

// file: hdl/nand_cycle.sv
// pin sequencer: one command, address or data byte cycle per request
module nand_cycle (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // request
  input wire logic req,
  input wire nand_feat_pkg::cyc_kind_type kind,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] io_in,
  output logic done,
  output logic [7:0] byte_out,
  // pins
  output nand_feat_pkg::nand_pins_type pins
);
  import nand_feat_pkg::*;
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_LOW = 2'b01,
    C_HIGH = 2'b10
  } cyc_fsm_type;
  typedef struct packed {
    cyc_fsm_type fsm;
    logic [CNT_W-1:0] cnt;
    cyc_kind_type kind;
    logic done;
    logic [7:0] rd;
    nand_pins_type pins;
  } cyc_state_type;
  cyc_state_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.fsm)
      C_IDLE: begin
        st_next.pins.cle = 1'b0;
        st_next.pins.ale = 1'b0;
        st_next.pins.io_oe = 1'b0;
        if (req) begin
          st_next.kind = kind;
          st_next.pins.ce_n = 1'b0;
          st_next.pins.io_out = byte_in;
          st_next.cnt = CNT_W'(WP_CYC);
          st_next.fsm = C_LOW;
          case (kind)
            CYC_CMD: begin
              st_next.pins.cle = 1'b1;
              st_next.pins.io_oe = 1'b1;
              st_next.pins.we_n = 1'b0;
            end
            CYC_ADDR: begin
              st_next.pins.ale = 1'b1;
              st_next.pins.io_oe = 1'b1;
              st_next.pins.we_n = 1'b0;
            end
            CYC_DIN: begin
              st_next.pins.io_oe = 1'b1;
              st_next.pins.we_n = 1'b0;
            end
            CYC_DOUT: begin
              st_next.pins.re_n = 1'b0;
              st_next.cnt = CNT_W'(REA_CYC);
            end
            default: begin
              // plain wait, strobes untouched
              st_next.cnt = CNT_W'(ADL_CYC);
            end
          endcase
        end
      end
      C_LOW: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end else begin
          // command, address or parameter byte latched by the device on this rising edge
          st_next.pins.we_n = 1'b1;
          if (st_reg.kind == CYC_DOUT) begin
            st_next.rd = io_in; // one byte per read strobe
          end
          st_next.pins.re_n = 1'b1;
          st_next.cnt = CNT_W'(WP_CYC);
          st_next.fsm = C_HIGH;
        end
      end
      C_HIGH: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end else begin
          st_next.done = 1'b1;
          st_next.fsm = C_IDLE;
        end
      end
      default: begin
        st_next.fsm = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '{fsm: C_IDLE, cnt: '0, kind: CYC_WAIT, done: 1'b0, rd: 8'h00,
                  pins: '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                          io_out: 8'h00, io_oe: 1'b0}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;
  assign byte_out = st_reg.rd;
  assign pins = st_reg.pins;
endmodule

// file: hdl/nand_feat_host.sv
// host controller issuing set-features and get-features sequences
// Overview of operation
// - set code writes P1..P4 to a feature, get code reads them back
// - ecc on: set code, address 90h, P1 08h, zeros, then wait busy
// - ecc off: same sequence with P1 00h, then wait busy
// - host sends address then waits address-to-data delay before P1
// - after get address device busy; after status polling issue read mode
// - after busy ends host reads four parameter bytes
module nand_feat_host (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // ahb-lite slave
  input wire nand_feat_pkg::ahb_req_type AHB_REQ,
  output nand_feat_pkg::ahb_rsp_type AHB_RSP,
  // nand pins
  output nand_feat_pkg::nand_pins_type NAND_PINS,
  input wire logic [7:0] NAND_IO_IN,
  input wire logic NAND_RB_N
);
  import nand_feat_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CHECK = 4'b0001,
    S_CMD = 4'b0010,
    S_ADDR = 4'b0011,
    S_ADL = 4'b0100,
    S_DIN = 4'b0101,
    S_WB = 4'b0110,
    S_BUSY = 4'b0111,
    S_STAT = 4'b1000,
    S_STAT_RD = 4'b1001,
    S_RDMODE = 4'b1010,
    S_DOUT = 4'b1011
  } host_fsm_type;

  typedef struct packed {
    host_fsm_type fsm;
    logic get_op;
    logic [7:0] feat_addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] idx;
    logic req;
    cyc_kind_type kind;
    logic [7:0] byte_o;
    logic busy;
    logic done_flag;
    logic bus_pend;
    logic bus_wr;
    logic [7:0] bus_addr;
    ahb_rsp_type rsp;
  } host_state_type;

  host_state_type st_reg, st_next;
  logic cyc_done;
  logic [7:0] cyc_byte;
  logic rb_level;

  rb_sync u_rb (
    .CLK(CLK),
    .RST(RST),
    .pin_in(NAND_RB_N),
    .level_out(rb_level)
  );

  nand_cycle u_cyc (
    .CLK(CLK),
    .RST(RST),
    .req(st_reg.req),
    .kind(st_reg.kind),
    .byte_in(st_reg.byte_o),
    .io_in(NAND_IO_IN),
    .done(cyc_done),
    .byte_out(cyc_byte),
    .pins(NAND_PINS)
  );

  always_comb begin
    st_next = st_reg;
    st_next.req = 1'b0;
    st_next.rsp.hresp = 1'b0;
    st_next.rsp.hreadyout = 1'b1;
    // bus data phase: writes land here, reads were prepared at address phase
    if (st_reg.bus_pend) begin
      st_next.bus_pend = 1'b0;
      if (st_reg.bus_wr) begin
        case (st_reg.bus_addr)
          CTRL_OFS: begin
            // commands only launch while the controller is idle
            if (AHB_REQ.hwdata[CTRL_GO_BIT] && !st_reg.busy) begin
              st_next.get_op = AHB_REQ.hwdata[CTRL_GET_BIT];
              st_next.busy = 1'b1;
              st_next.done_flag = 1'b0;
              st_next.fsm = S_CHECK;
            end
          end
          ADDR_OFS: st_next.feat_addr = AHB_REQ.hwdata[7:0];
          WDATA_OFS: st_next.wdata = AHB_REQ.hwdata;
          default: begin
          end
        endcase
      end
    end
    if (AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans[1]) begin
      st_next.bus_pend = 1'b1;
      st_next.bus_wr = AHB_REQ.hwrite;
      st_next.bus_addr = AHB_REQ.haddr[7:0];
      case (AHB_REQ.haddr[7:0])
        CTRL_OFS: st_next.rsp.hrdata = {30'h0, st_reg.get_op, 1'b0};
        ADDR_OFS: st_next.rsp.hrdata = {24'h0, st_reg.feat_addr};
        WDATA_OFS: st_next.rsp.hrdata = st_reg.wdata;
        RDATA_OFS: st_next.rsp.hrdata = st_reg.rdata;
        STATUS_OFS: st_next.rsp.hrdata = {30'h0, st_reg.done_flag, st_reg.busy};
        default: st_next.rsp.hrdata = 32'h0000_0000;
      endcase
    end
    case (st_reg.fsm)
      S_IDLE: begin
      end
      S_CHECK: begin
        // target must be idle before a feature command
        if (rb_level) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_CMD;
          st_next.byte_o = st_reg.get_op ? CMD_GET : CMD_SET;
          st_next.fsm = S_CMD;
        end
      end
      S_CMD: begin
        if (cyc_done) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_ADDR;
          st_next.byte_o = st_reg.feat_addr;
          st_next.fsm = S_ADDR;
        end
      end
      S_ADDR: begin
        if (cyc_done) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_WAIT;
          st_next.idx = 2'd0;
          st_next.fsm = st_reg.get_op ? S_WB : S_ADL;
        end
      end
      S_ADL: begin
        // address-to-data delay before the first parameter
        if (cyc_done) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_DIN;
          st_next.byte_o = st_reg.wdata[7:0];
          st_next.fsm = S_DIN;
        end
      end
      S_DIN: begin
        if (cyc_done) begin
          if (st_reg.idx == 2'd3) begin
            st_next.req = 1'b1;
            st_next.kind = CYC_WAIT;
            st_next.fsm = S_WB;
          end else begin
            st_next.idx = st_reg.idx + 2'd1;
            st_next.req = 1'b1;
            st_next.kind = CYC_DIN;
            // P1 first, then P2..P4 from the upper bytes
            st_next.byte_o = st_reg.wdata[8 * (32'(st_reg.idx) + 1) +: 8];
          end
        end
      end
      S_WB: begin
        // give the device time to pull ready/busy low
        if (cyc_done) begin
          st_next.fsm = S_BUSY;
        end
      end
      S_BUSY: begin
        // wait covers both the feature time and the interface change time
        if (rb_level) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_CMD;
          st_next.byte_o = CMD_STATUS;
          st_next.fsm = S_STAT;
        end
      end
      S_STAT: begin
        if (cyc_done) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_DOUT;
          st_next.fsm = S_STAT_RD;
        end
      end
      S_STAT_RD: begin
        if (cyc_done) begin
          if (!cyc_byte[STATUS_RDY_BIT]) begin
            // still busy: poll status again
            st_next.req = 1'b1;
            st_next.kind = CYC_DOUT;
          end else if (st_reg.get_op) begin
            // status output must be turned off before data
            st_next.req = 1'b1;
            st_next.kind = CYC_CMD;
            st_next.byte_o = CMD_READ_MODE;
            st_next.fsm = S_RDMODE;
          end else begin
            st_next.busy = 1'b0;
            st_next.done_flag = 1'b1;
            st_next.fsm = S_IDLE;
          end
        end
      end
      S_RDMODE: begin
        if (cyc_done) begin
          st_next.req = 1'b1;
          st_next.kind = CYC_DOUT;
          st_next.idx = 2'd0;
          st_next.fsm = S_DOUT;
        end
      end
      S_DOUT: begin
        if (cyc_done) begin
          // bytes arrive P1..P4 into lanes 0..3
          st_next.rdata[8 * 32'(st_reg.idx) +: 8] = cyc_byte;
          if (st_reg.idx == 2'd3) begin
            st_next.busy = 1'b0;
            st_next.done_flag = 1'b1;
            st_next.fsm = S_IDLE;
          end else begin
            st_next.idx = st_reg.idx + 2'd1;
            st_next.req = 1'b1;
            st_next.kind = CYC_DOUT;
          end
        end
      end
      default: begin
        st_next.fsm = S_IDLE;
      end
    endcase
  end

  // no reset command is ever sent here, so device settings persist
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '{fsm: S_IDLE, get_op: 1'b0, feat_addr: ADDR_RESET[7:0],
                  wdata: WDATA_RESET, rdata: RDATA_RESET, idx: 2'd0,
                  req: 1'b0, kind: CYC_WAIT, byte_o: 8'h00, busy: 1'b0,
                  done_flag: 1'b0, bus_pend: 1'b0, bus_wr: 1'b0, bus_addr: 8'h00,
                  rsp: '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign AHB_RSP = st_reg.rsp;
endmodule

// file: tb/nand_dev_model.sv
// behavioural feature-handling device on the far side of the pins
module nand_dev_model (
  // pins from the controller
  input wire nand_feat_pkg::nand_pins_type pins,
  input wire logic [31:0] busy_ns,
  // device outputs
  output logic [7:0] io,
  output logic rb_n,
  output int errs
);
  timeunit 1ns;
  timeprecision 1ps;
  import nand_feat_pkg::*;
  logic [7:0] cmd, faddr, dq, timing, array;
  logic [31:0] pw;
  logic [2:0] n;
  realtime t_addr;
  // power-on defaults only; no command, reset included, clears them
  initial begin
    rb_n = 1'b1;
    errs = 0;
    timing = 8'h00;
    array = 8'h00;
    dq = 8'h00;
    cmd = 8'h00;
  end
  // released bus shows the inverse so a stale sample cannot pass
  assign io = (pins.ce_n || pins.re_n) ? ~dq :
    (cmd == CMD_STATUS) ? {1'b1, rb_n, 6'h00} : dq;
  // drive and pull-down stay at full strength, so they read zero
  function automatic logic [31:0] feat_word(input logic [7:0] a);
    case (a)
      FEAT_TIMING: return {24'h0, timing};
      FEAT_ARRAY: return {24'h0, array};
      default: return 32'h0;
    endcase
  endfunction
  task automatic go_busy();
    fork
      begin
        rb_n = 1'b0;
        #(busy_ns);
        rb_n = 1'b1;
      end
    join_none
  endtask
  always @(posedge pins.we_n) begin
    if (pins.ce_n === 1'b0 && pins.cle) begin
      if ((pins.io_out == CMD_SET || pins.io_out == CMD_GET) && !rb_n) begin
        errs++;
      end
      cmd = pins.io_out;
      n = 3'd0;
    end else if (pins.ce_n === 1'b0 && pins.ale) begin
      faddr = pins.io_out;
      t_addr = $realtime;
      if (cmd == CMD_GET) begin
        pw = feat_word(faddr);
        go_busy();
      end
    end else if (pins.ce_n === 1'b0 && cmd == CMD_SET && n < 3'd4) begin
      if (n == 3'd0 && $realtime - t_addr < T_ADL_NS) begin
        errs++;
      end
      pw[8 * n +: 8] = pins.io_out;
      n++;
      if (n == 3'd4) begin
        if (faddr == FEAT_TIMING) begin
          timing = {5'h00, pw[2:0]};
        end else if (faddr == FEAT_ARRAY) begin
          array = pw[7:0] & 8'h0b;
        end
        // interface type never changes here, so plain busy time
        go_busy();
      end
    end
  end
  always @(negedge pins.re_n) begin
    if (pins.ce_n === 1'b0 && cmd != CMD_STATUS) begin
      dq = pw[8 * n[1:0] +: 8];
      n++;
    end
  end
endmodule

// file: tb/nand_feat_host_assertions.sv
// checker on the controller's ports
module nand_feat_host_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // watched ports
  input wire nand_feat_pkg::ahb_req_type AHB_REQ,
  input wire nand_feat_pkg::ahb_rsp_type AHB_RSP,
  input wire nand_feat_pkg::nand_pins_type NAND_PINS,
  input wire logic [7:0] NAND_IO_IN,
  input wire logic NAND_RB_N
);
  timeunit 1ns;
  timeprecision 1ps;
  import nand_feat_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_bus_okay;
    AHB_RSP.hreadyout && !AHB_RSP.hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready okay");
  property p_we_width;
    $fell(NAND_PINS.we_n) |-> (!NAND_PINS.we_n)[*8] ##1 NAND_PINS.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width off");
  property p_re_width;
    $fell(NAND_PINS.re_n) |-> (!NAND_PINS.re_n)[*6] ##1 NAND_PINS.re_n;
  endproperty
  a_re_width: assert property (p_re_width) else $error("read strobe width off");
  property p_strobe_excl;
    !(!NAND_PINS.we_n && !NAND_PINS.re_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
  property p_latch_qual;
    !NAND_PINS.we_n |-> !NAND_PINS.ce_n && NAND_PINS.io_oe && !(NAND_PINS.cle && NAND_PINS.ale);
  endproperty
  a_latch_qual: assert property (p_latch_qual) else $error("write cycle badly qualified");
  property p_read_release;
    !NAND_PINS.re_n |-> !NAND_PINS.ce_n && !NAND_PINS.io_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus driven during read");
  property p_feat_idle;
    $fell(NAND_PINS.we_n) && NAND_PINS.cle &&
      (NAND_PINS.io_out == CMD_SET || NAND_PINS.io_out == CMD_GET)
      |-> NAND_RB_N && $past(NAND_RB_N, 3);
  endproperty
  a_feat_idle: assert property (p_feat_idle) else $error("feature command while busy");
  property p_busy_quiet;
    $fell(NAND_PINS.we_n) || $fell(NAND_PINS.re_n) |-> $past(NAND_RB_N);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while device busy");
  property p_data_stable;
    !NAND_PINS.we_n && !$fell(NAND_PINS.we_n) |->
      $stable(NAND_PINS.io_out) && $stable(NAND_PINS.cle) && $stable(NAND_PINS.ale);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("byte changed in strobe");
endmodule

bind nand_feat_host nand_feat_host_assertions chk_u (.CLK(CLK), .RST(RST), .AHB_REQ(AHB_REQ),
  .AHB_RSP(AHB_RSP), .NAND_PINS(NAND_PINS), .NAND_IO_IN(NAND_IO_IN), .NAND_RB_N(NAND_RB_N));

// file: tb/nand_feature_set_get_tb_top.sv
// testbench: register bus tasks and feature scenarios
module nand_feature_set_get_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nand_feat_pkg::*;
  logic CLK, RST, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, d;
  nand_feat_pkg::ahb_req_type ahb_req;
  nand_feat_pkg::ahb_rsp_type ahb_rsp;
  nand_feat_pkg::nand_pins_type pins;
  logic [7:0] dev_io;
  logic rb_n;
  int busy_ns, dev_errs, fail_count, checked;
  logic [7:0] modes [4];
  assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
    hsize: 3'b010, hready: ahb_rsp.hreadyout, hwdata: hwdata};
  nand_feat_host dut_u (.CLK(CLK), .RST(RST), .AHB_REQ(ahb_req), .AHB_RSP(ahb_rsp),
    .NAND_PINS(pins), .NAND_IO_IN(dev_io), .NAND_RB_N(rb_n));
  nand_dev_model dev_u (.pins(pins), .busy_ns(busy_ns), .io(dev_io), .rb_n(rb_n),
    .errs(dev_errs));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // no fixed latency assumed: wait for hready, the watchdog bounds a hang
  task automatic wait_ready();
    @(posedge CLK);
    while (ahb_rsp.hreadyout !== 1'b1) begin
      @(posedge CLK);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = ahb_rsp.hrdata;
  endtask
  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    expect_eq(r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, a, v, r);
  endtask
  task automatic wait_done();
    logic [31:0] s;
    s = 32'h0;
    while (s[STAT_RDY_BIT] !== 1'b1) begin
      bus(1'b0, STATUS_OFS, 32'h0, s);
    end
  endtask
  task automatic op(input logic get, input logic [7:0] fa, input logic [31:0] v);
    wr(ADDR_OFS, {24'h0, fa});
    wr(WDATA_OFS, v);
    wr(CTRL_OFS, {30'h0, get, 1'b1});
    wait_done();
  endtask
  task automatic set_get(input logic [7:0] fa, input logic [31:0] v, input logic [31:0] exp);
    op(1'b0, fa, v);
    op(1'b1, fa, 32'h0);
    rd_chk(RDATA_OFS, exp);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bound well above the longest expected run
  initial begin
    #600us;
    fail_count++;
    test_done();
  end
  initial begin
    RST = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    busy_ns = 2000;
    fail_count = 0;
    checked = 0;
    modes = '{ARRAY_OTP, ARRAY_OTP_PROT, ARRAY_NORMAL, ARRAY_ECC_ON};
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd_chk(ADDR_OFS, ADDR_RESET);
    rd_chk(WDATA_OFS, WDATA_RESET);
    rd_chk(RDATA_OFS, RDATA_RESET);
    rd_chk(STATUS_OFS, 32'h0);
    wr(8'h14, 32'hffff_ffff);
    rd_chk(8'h14, 32'h0);
    $display("test registers done");
    set_get(FEAT_ARRAY, 32'h0000_0008, {24'h0, ARRAY_ECC_ON});
    busy_ns = 300;
    set_get(FEAT_ARRAY, 32'h0000_0000, {24'h0, ARRAY_NORMAL});
    $display("test ecc done");
    foreach (modes[i]) begin
      set_get(FEAT_ARRAY, {24'h0, modes[i]}, {24'h0, modes[i]});
    end
    $display("test array modes done");
    // upper lanes carry junk: only P1 low bits may come back
    for (int m = 0; m <= 5; m++) begin
      set_get(FEAT_TIMING, {24'haabbcc, m[7:0]}, {24'h0, m[7:0]});
    end
    $display("test timing modes done");
    // controller reset in mid-run: device settings must survive it
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd_chk(STATUS_OFS, 32'h0);
    rd_chk(ADDR_OFS, ADDR_RESET);
    rd_chk(RDATA_OFS, RDATA_RESET);
    op(1'b1, FEAT_ARRAY, 32'h0);
    rd_chk(RDATA_OFS, {24'h0, ARRAY_ECC_ON});
    $display("test reset retention done");
    set_get(8'h00, 32'h1234_5678, 32'h0);
    set_get(8'hff, 32'h8765_4321, 32'h0);
    $display("test reserved addresses done");
    busy_ns = 3000;
    wr(ADDR_OFS, {24'h0, FEAT_ARRAY});
    wr(WDATA_OFS, {24'h0, ARRAY_OTP});
    wr(CTRL_OFS, 32'h1);
    rd_chk(STATUS_OFS, 32'h1);
    wr(CTRL_OFS, 32'h3);
    wait_done();
    rd_chk(STATUS_OFS, 32'h2);
    bus(1'b0, CTRL_OFS, 32'h0, d);
    expect_eq(d & 32'h2, 32'h0);
    busy_ns = 300;
    op(1'b1, FEAT_ARRAY, 32'h0);
    rd_chk(RDATA_OFS, {24'h0, ARRAY_OTP});
    expect_eq(32'(dev_errs), 32'h0);
    $display("test busy refusal done");
    test_done();
  end
endmodule
